/* hdl/pflash_protect_pkg.sv */
/*
  Constants, field layout and types shared by the program-flash protection logic.
  Assumes a single 20 MHz bus clock and an 18-bit global flash address space.
*/
// Overview of operation
// (RULE_01) A new protection setting is taken only if it keeps or enlarges the protected region, otherwise refused.
// (RULE_02) After reset the setting is loaded from the protection byte at global address 0x3_FF0C.
// (RULE_03) A double-bit fault on that reset read clears the open selector and bit 6 and sets bits 5 to 0 (0x3F) for full protection.
// (RULE_04) A program or erase aimed at a protected area is refused and raises the protection violation flag.
// (RULE_05) A whole-block erase is refused when any sector of that block is protected.
// (RULE_06) Software must unprotect the upper sector before it reprograms the stored protection byte.
// (RULE_07) Each program or erase target is checked against the current protected range before it is launched.
package pflash_protect_pkg;
  localparam int ADDR_W = 18;
  localparam int SET_W = 8;
  localparam int OFS_W = 17;
  localparam int SEC_SHIFT = 9;
  localparam int SEC_IDX_W = 7;
  localparam int SEC_NUM = 128;
  localparam int SIZE_W = 2;
  localparam logic [ADDR_W-1:0] PF_BASE = 18'h30000;
  localparam logic [ADDR_W-1:0] CFG_ADDR = 18'h3FF0C;
  localparam logic [OFS_W-1:0] PF_SIZE = 17'h10000;
  localparam logic [OFS_W-1:0] HI_MIN = 17'h00800;
  localparam logic [OFS_W-1:0] LO_MIN = 17'h00400;
  localparam int OPEN_BIT = 7;
  localparam int HDIS_BIT = 5;
  localparam int HS_LSB = 3;
  localparam int LDIS_BIT = 2;
  localparam int LS_LSB = 0;
  localparam logic [SET_W-1:0] SET_MASK = 8'hBF;
  localparam logic [SET_W-1:0] FULL_PROT = 8'h3F;
  localparam logic [SET_W-1:0] SET_RESET = 8'h3F;

  typedef enum logic [1:0] {
    CMD_PROGRAM,
    CMD_ERASE_SECTOR,
    CMD_ERASE_BLOCK,
    CMD_OTHER
  } cmd_kind_t;

  typedef enum logic [1:0] {
    ST_REQ,
    ST_WAIT,
    ST_READY
  } state_t;
endpackage

/* hdl/pflash_sector_map.sv */
/*
  Expands a protection setting into one protected flag per program-flash sector.
  Purely combinational; the caller registers whatever it needs.
*/
`timescale 1ns/1ps
module pflash_sector_map (
  input wire logic [pflash_protect_pkg::SET_W-1:0] setting_in,
  output logic [pflash_protect_pkg::SEC_NUM-1:0] prot_vec_out
);
  function automatic logic sector_protected(input logic [pflash_protect_pkg::SET_W-1:0] s,
                                            input logic [pflash_protect_pkg::OFS_W-1:0] start);
    logic [pflash_protect_pkg::OFS_W-1:0] hi_size;
    logic [pflash_protect_pkg::OFS_W-1:0] lo_size;
    logic in_range;
    hi_size = pflash_protect_pkg::HI_MIN << s[pflash_protect_pkg::HS_LSB +: pflash_protect_pkg::SIZE_W];
    lo_size = pflash_protect_pkg::LO_MIN << s[pflash_protect_pkg::LS_LSB +: pflash_protect_pkg::SIZE_W];
    in_range = (!s[pflash_protect_pkg::HDIS_BIT] && (start >= pflash_protect_pkg::PF_SIZE - hi_size)) ||
               (!s[pflash_protect_pkg::LDIS_BIT] && (start < lo_size));
    // With the open selector clear the ranges name the unprotected area, so disabling both protects all.
    sector_protected = s[pflash_protect_pkg::OPEN_BIT] ? in_range : !in_range;
  endfunction

  genvar i;
  generate
    for (i = 0; i < pflash_protect_pkg::SEC_NUM; i = i + 1) begin : g_sec
      localparam logic [pflash_protect_pkg::OFS_W-1:0] START =
        pflash_protect_pkg::OFS_W'(i) << pflash_protect_pkg::SEC_SHIFT;
      assign prot_vec_out[i] = sector_protected(setting_in, START);
    end
  endgenerate
endmodule // pflash_sector_map

/* hdl/program_flash_protection.sv */
/*
  Program-flash protection: reset load of the setting, grow-only updates, command screening
  and the sticky protection violation flag of the flash status register.
  Assumes the flash read port answers the reset read with rd_valid_in and that command,
  write and clear requests come from logic on the same clock.
*/
`timescale 1ns/1ps
module program_flash_protection (
  input wire logic clk_in,
  input wire logic srst_in,
  output logic rd_req_out,
  output logic [pflash_protect_pkg::ADDR_W-1:0] rd_addr_out,
  input wire logic rd_valid_in,
  input wire logic [pflash_protect_pkg::SET_W-1:0] rd_data_in,
  input wire logic rd_dbl_fault_in,
  input wire logic set_wr_in,
  input wire logic [pflash_protect_pkg::SET_W-1:0] set_wr_data_in,
  output logic set_wr_done_out,
  output logic set_wr_refused_out,
  output logic [pflash_protect_pkg::SET_W-1:0] pflash_protect_setting_out,
  output logic load_done_out,
  input wire logic cmd_valid_in,
  input wire pflash_protect_pkg::cmd_kind_t cmd_kind_in,
  input wire logic [pflash_protect_pkg::ADDR_W-1:0] cmd_addr_in,
  output logic cmd_ready_out,
  output logic cmd_launch_out,
  output logic cmd_refused_out,
  input wire logic viol_clear_in,
  output logic protect_violation_flag_out
);
  pflash_protect_pkg::state_t state_ff, nxt_state;
  logic [pflash_protect_pkg::SET_W-1:0] setting_ff, nxt_setting;
  logic wr_done_ff, nxt_wr_done;
  logic wr_refused_ff, nxt_wr_refused;
  logic launch_ff, nxt_launch;
  logic refused_ff, nxt_refused;
  logic viol_ff, nxt_viol;
  logic [pflash_protect_pkg::SEC_NUM-1:0] cur_vec;
  logic [pflash_protect_pkg::SEC_NUM-1:0] new_vec;
  logic [pflash_protect_pkg::SET_W-1:0] wr_value;
  logic shrink;
  logic in_pflash;
  logic target_prot;
  logic any_prot;
  logic cmd_take;
  logic cmd_bad;

  assign wr_value = set_wr_data_in & pflash_protect_pkg::SET_MASK;

  pflash_sector_map u_cur_map (
    .setting_in(setting_ff),
    .prot_vec_out(cur_vec)
  );

  pflash_sector_map u_new_map (
    .setting_in(wr_value),
    .prot_vec_out(new_vec)
  );

  // A sector that is protected now must stay protected under the proposed value.
  assign shrink = |(cur_vec & ~new_vec); // RULE_01
  assign in_pflash = cmd_addr_in >= pflash_protect_pkg::PF_BASE;
  assign target_prot = in_pflash && cur_vec[cmd_addr_in[pflash_protect_pkg::SEC_SHIFT +: pflash_protect_pkg::SEC_IDX_W]];
  assign any_prot = |cur_vec;
  assign cmd_ready_out = state_ff == pflash_protect_pkg::ST_READY;
  assign cmd_take = cmd_valid_in && cmd_ready_out;
  assign rd_req_out = state_ff == pflash_protect_pkg::ST_REQ;
  assign rd_addr_out = pflash_protect_pkg::CFG_ADDR; // RULE_02

  always_comb begin
    unique case (cmd_kind_in)
      pflash_protect_pkg::CMD_PROGRAM: cmd_bad = target_prot; // RULE_04
      pflash_protect_pkg::CMD_ERASE_SECTOR: cmd_bad = target_prot; // RULE_04
      pflash_protect_pkg::CMD_ERASE_BLOCK: cmd_bad = in_pflash && any_prot; // RULE_05
      pflash_protect_pkg::CMD_OTHER: cmd_bad = 1'b0;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_setting = setting_ff;
    nxt_wr_done = 1'b0;
    nxt_wr_refused = 1'b0;
    unique case (state_ff)
      pflash_protect_pkg::ST_REQ: begin
        nxt_state = pflash_protect_pkg::ST_WAIT;
      end
      pflash_protect_pkg::ST_WAIT: begin
        if (rd_valid_in) begin
          nxt_state = pflash_protect_pkg::ST_READY;
          if (rd_dbl_fault_in) begin
            nxt_setting = pflash_protect_pkg::FULL_PROT; // RULE_03
          end else begin
            nxt_setting = rd_data_in & pflash_protect_pkg::SET_MASK; // RULE_02
          end
        end
      end
      pflash_protect_pkg::ST_READY: begin
        if (set_wr_in) begin
          if (shrink) begin
            nxt_wr_refused = 1'b1; // RULE_01
          end else begin
            nxt_setting = wr_value; // RULE_01
            nxt_wr_done = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_ff <= pflash_protect_pkg::ST_REQ;
      setting_ff <= pflash_protect_pkg::SET_RESET;
      wr_done_ff <= 1'b0;
      wr_refused_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      setting_ff <= nxt_setting;
      wr_done_ff <= nxt_wr_done;
      wr_refused_ff <= nxt_wr_refused;
    end
  end

  always_comb begin
    nxt_launch = cmd_take && !cmd_bad; // RULE_07
    nxt_refused = cmd_take && cmd_bad; // RULE_07
    // A violation in the same cycle as a clear keeps the flag set, so no event is lost.
    nxt_viol = nxt_refused || (viol_ff && !viol_clear_in); // RULE_04
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      launch_ff <= 1'b0;
      refused_ff <= 1'b0;
      viol_ff <= 1'b0;
    end else begin
      launch_ff <= nxt_launch;
      refused_ff <= nxt_refused;
      viol_ff <= nxt_viol;
    end
  end

  assign set_wr_done_out = wr_done_ff;
  assign set_wr_refused_out = wr_refused_ff;
  assign pflash_protect_setting_out = setting_ff;
  assign load_done_out = cmd_ready_out;
  assign cmd_launch_out = launch_ff;
  assign cmd_refused_out = refused_ff;
  assign protect_violation_flag_out = viol_ff;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence wr_take_s;
    set_wr_in && cmd_ready_out;
  endsequence

  sequence cmd_take_s;
    cmd_valid_in && cmd_ready_out;
  endsequence

  sequence load_ok_s;
    state_ff == pflash_protect_pkg::ST_WAIT && rd_valid_in && !rd_dbl_fault_in;
  endsequence

  sequence load_fault_s;
    state_ff == pflash_protect_pkg::ST_WAIT && rd_valid_in && rd_dbl_fault_in;
  endsequence

  shrink_refused_a: assert property (wr_take_s ##0 shrink |=> // RULE_01
    set_wr_refused_out && !set_wr_done_out && $stable(pflash_protect_setting_out))
    else $error("Shrinking protection write was not refused.");

  grow_taken_a: assert property (wr_take_s ##0 !shrink |=> // RULE_01
    set_wr_done_out && pflash_protect_setting_out == ($past(set_wr_data_in) & pflash_protect_pkg::SET_MASK))
    else $error("Growing protection write was not taken.");

  reset_read_a: assert property ($fell(srst_in) |-> rd_req_out ##1 !rd_req_out) // RULE_02
    else $error("Reset read of the protection byte was not issued once.");

  load_value_a: assert property (load_ok_s |=> // RULE_02
    load_done_out && pflash_protect_setting_out == ($past(rd_data_in) & pflash_protect_pkg::SET_MASK))
    else $error("Protection byte was not loaded after reset.");

  fault_full_a: assert property (load_fault_s |=> // RULE_03
    pflash_protect_setting_out == pflash_protect_pkg::FULL_PROT && !pflash_protect_setting_out[pflash_protect_pkg::OPEN_BIT])
    else $error("Double fault did not force full protection.");

  viol_raise_a: assert property (cmd_take_s ##0 target_prot && cmd_kind_in != pflash_protect_pkg::CMD_OTHER |=> // RULE_04
    cmd_refused_out && protect_violation_flag_out && !cmd_launch_out)
    else $error("Protected target did not raise a violation.");

  viol_hold_a: assert property (protect_violation_flag_out && !viol_clear_in |=> protect_violation_flag_out) // RULE_04
    else $error("Violation flag dropped without a clear.");

  block_erase_a: assert property (cmd_take_s ##0 cmd_kind_in == pflash_protect_pkg::CMD_ERASE_BLOCK && // RULE_05
    in_pflash && any_prot |=> cmd_refused_out)
    else $error("Block erase ran with a protected sector.");

  launch_check_a: assert property (cmd_launch_out |-> $past(cmd_valid_in) && !$past(cmd_bad)) // RULE_07
    else $error("Command launched without a clean protection check.");

  idle_quiet_a: assert property (!cmd_ready_out |=> !cmd_launch_out && !cmd_refused_out) // RULE_07
    else $error("Command handled before the protection load finished.");

  refuse_flags_a: assert property (cmd_refused_out |-> protect_violation_flag_out) // RULE_04
    else $error("Refused command left the violation flag clear.");

  cmd_onehot_a: assert property (!(cmd_launch_out && cmd_refused_out)) // RULE_07
    else $error("Command both launched and refused.");

  wr_onehot_a: assert property (!(set_wr_done_out && set_wr_refused_out)) // RULE_01
    else $error("Protection write both taken and refused.");

  low_addr_a: assert property (cmd_take_s ##0 !in_pflash |=> cmd_launch_out && !cmd_refused_out) // RULE_04
    else $error("Command outside program flash was refused.");

  viol_clear_a: assert property (viol_clear_in && !(cmd_valid_in && cmd_ready_out && cmd_bad) |=> // RULE_04
    !protect_violation_flag_out)
    else $error("Violation flag survived a clear.");

  setting_hold_a: assert property (cmd_ready_out && !set_wr_in |=> $stable(pflash_protect_setting_out)) // RULE_01
    else $error("Protection setting changed without a write.");
endmodule // program_flash_protection

/* tb/flash_read_model.sv */
/*
  Behavioural flash read port that answers the reset read of the protection byte.
  Assumes the design issues its request on the same clock, at most once per reset.
*/
`timescale 1ns/1ps
module flash_read_model (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic rd_req_in,
  input wire logic [pflash_protect_pkg::ADDR_W-1:0] rd_addr_in,
  input wire logic [7:0] byte_in,
  input wire logic fault_in,
  input wire logic [3:0] dly_in,
  output logic rd_valid_out,
  output logic [pflash_protect_pkg::SET_W-1:0] rd_data_out,
  output logic rd_dbl_fault_out
);
  logic [7:0] word;
  initial begin
    rd_valid_out = 1'b0;
    rd_data_out = 8'h00;
    rd_dbl_fault_out = 1'b0;
    forever begin
      @(posedge clk_in);
      // A request held up during reset is not one the design waits on, and answering it would leave the model busy.
      if (rd_req_in && !srst_in) begin
        // Any other address returns the inverse, so a wrong address cannot pass.
        word = (rd_addr_in === pflash_protect_pkg::CFG_ADDR) ? byte_in : ~byte_in;
        repeat (dly_in) @(posedge clk_in);
        rd_valid_out <= 1'b1;
        rd_data_out <= word;
        rd_dbl_fault_out <= fault_in;
        @(posedge clk_in);
        rd_valid_out <= 1'b0;
        rd_data_out <= ~word;
      end else begin
        // Idle data and fault lines toggle so that a stale sample is never mistaken for data.
        rd_data_out <= ~rd_data_out;
        rd_dbl_fault_out <= ~rd_dbl_fault_out;
      end
    end
  end
endmodule // flash_read_model

/* tb/program_flash_protection_test.sv */
/*
  Self-checking bench for the program-flash protection block.
  Assumes the flash read model answers the reset read; all other inputs come from here.
*/
`timescale 1ns/1ps
module program_flash_protection_test;
  logic clk_in, srst_in, rd_req, rd_valid, rd_fault, set_wr, wr_done, wr_ref, load_done;
  logic cmd_valid, cmd_ready, launch, refused, viol_clear, flag, fault_sel;
  logic [17:0] rd_addr, cmd_addr;
  logic [7:0] rd_data, wr_data, setting, stored;
  logic [15:0] lfsr;
  logic [3:0] dly, mexp;
  logic [3:0] expq[$];
  pflash_protect_pkg::cmd_kind_t kind;
  int fail_count, n_compared;

  program_flash_protection dut (.clk_in(clk_in), .srst_in(srst_in), .rd_req_out(rd_req),
    .rd_addr_out(rd_addr), .rd_valid_in(rd_valid), .rd_data_in(rd_data), .rd_dbl_fault_in(rd_fault),
    .set_wr_in(set_wr), .set_wr_data_in(wr_data), .set_wr_done_out(wr_done), .set_wr_refused_out(wr_ref),
    .pflash_protect_setting_out(setting), .load_done_out(load_done), .cmd_valid_in(cmd_valid),
    .cmd_kind_in(kind), .cmd_addr_in(cmd_addr), .cmd_ready_out(cmd_ready), .cmd_launch_out(launch),
    .cmd_refused_out(refused), .viol_clear_in(viol_clear), .protect_violation_flag_out(flag));
  flash_read_model flash (.clk_in(clk_in), .srst_in(srst_in), .rd_req_in(rd_req), .rd_addr_in(rd_addr), .byte_in(stored),
    .fault_in(fault_sel), .dly_in(dly), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
    .rd_dbl_fault_out(rd_fault));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task test_done;
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task idle;
    set_wr = 1'b0;
    cmd_valid = 1'b0;
    @(negedge clk_in);
  endtask

  task do_reset(input logic [7:0] b, input logic f, input logic [3:0] d);
    int i;
    stored = b;
    fault_sel = f;
    dly = d;
    srst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    srst_in = 1'b0;
    check({7'h00, cmd_ready}, 8'h00);
    check({7'h00, rd_req}, 8'h01);
    for (i = 0; i < 40 && load_done !== 1'b1; i++) @(negedge clk_in);
    if (load_done !== 1'b1) begin
      fail_count++;
      test_done();
    end
    check(setting, f ? pflash_protect_pkg::FULL_PROT : (b & pflash_protect_pkg::SET_MASK));
    check({7'h00, cmd_ready}, 8'h01);
  endtask

  // Expected codes: 8 write taken, 4 write refused, 2 launched, 1 refused.
  task op(input logic w, input logic [1:0] k, input logic [17:0] a, input logic [7:0] d, input logic [3:0] e);
    set_wr = w;
    cmd_valid = ~w;
    kind = pflash_protect_pkg::cmd_kind_t'(k);
    cmd_addr = a;
    wr_data = d;
    expq.push_back(e);
    @(negedge clk_in);
  endtask

  always @(negedge clk_in) begin
    if ((wr_done | wr_ref | launch | refused) !== 1'b0) begin
      mexp = (expq.size() > 0) ? expq.pop_front() : 4'h0;
      check({4'h0, wr_done, wr_ref, launch, refused}, {4'h0, mexp});
    end
  end

  initial begin
    repeat (5000) @(posedge clk_in);
    fail_count++;
    test_done();
  end

  initial begin
    int i;
    srst_in = 1'b1;
    set_wr = 1'b0;
    cmd_valid = 1'b0;
    viol_clear = 1'b0;
    cmd_addr = 18'h00000;
    wr_data = 8'h00;
    kind = pflash_protect_pkg::CMD_PROGRAM;
    lfsr = 16'h136B;
    do_reset(8'hFF, 1'b0, 4'h3);
    op(1'b0, 2'h0, 18'h3FFF0, 8'h00, 4'h2);
    op(1'b0, 2'h2, 18'h30000, 8'h00, 4'h2);
    op(1'b1, 2'h0, 18'h00000, 8'hA0, 4'h8);
    check(setting, 8'hA0);
    op(1'b1, 2'h0, 18'h00000, 8'hBF, 4'h4);
    check(setting, 8'hA0);
    op(1'b1, 2'h0, 18'h00000, 8'hA1, 4'h8);
    op(1'b0, 2'h0, 18'h30000, 8'h00, 4'h1);
    op(1'b0, 2'h0, 18'h30800, 8'h00, 4'h2);
    op(1'b0, 2'h1, 18'h307FF, 8'h00, 4'h1);
    op(1'b0, 2'h2, 18'h30800, 8'h00, 4'h1);
    op(1'b0, 2'h3, 18'h30000, 8'h00, 4'h2);
    for (i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      op(1'b0, {1'b0, lfsr[0]}, {2'b00, lfsr}, 8'h00, 4'h2);
    end
    idle();
    check({7'h00, flag}, 8'h01);
    viol_clear = 1'b1;
    @(negedge clk_in);
    check({7'h00, flag}, 8'h00);
    // The clear stays up while a refusal lands, and the refusal must win.
    op(1'b0, 2'h0, 18'h30000, 8'h00, 4'h1);
    viol_clear = 1'b0;
    check({7'h00, flag}, 8'h01);
    idle();
    // The upper sector is unprotected here, so the stored byte may be changed.
    do_reset(8'h18, 1'b0, 4'h0);
    op(1'b0, 2'h0, 18'h3FFFF, 8'h00, 4'h2);
    op(1'b0, 2'h0, 18'h30000, 8'h00, 4'h2);
    op(1'b0, 2'h0, 18'h30400, 8'h00, 4'h1);
    op(1'b0, 2'h2, 18'h3FFFF, 8'h00, 4'h1);
    op(1'b1, 2'h0, 18'h00000, 8'h00, 4'h8);
    op(1'b1, 2'h0, 18'h00000, 8'h18, 4'h4);
    idle();
    do_reset(8'hFF, 1'b1, 4'h1);
    op(1'b0, 2'h0, 18'h10000, 8'h00, 4'h2);
    op(1'b0, 2'h0, 18'h3FFFF, 8'h00, 4'h1);
    idle();
    idle();
    if (expq.size() != 0) fail_count++;
    test_done();
  end
endmodule // program_flash_protection_test
